/* src/rbd_map.svh */
// register map, field positions and reset values of the ram based deserializer
`ifndef RBD_MAP_SVH
`define RBD_MAP_SVH

`define RBD_CTRL_OFS 5'h00
`define RBD_PATTERN_OFS 5'h04
`define RBD_TRIALS_OFS 5'h08
`define RBD_STATUS_OFS 5'h0C
`define RBD_WORD_OFS 5'h10
`define RBD_RDADDR_OFS 5'h14
`define RBD_RDDATA_OFS 5'h18

`define RBD_CTRL_MODE_LSB 0
`define RBD_CTRL_MODE_MSB 1
`define RBD_CTRL_MATCH_EN_BIT 2
`define RBD_CTRL_POLICY_BIT 3
`define RBD_CTRL_DOWN_BIT 4
`define RBD_CTRL_START_BIT 8

`define RBD_STATUS_MISSED_BIT 0
`define RBD_STATUS_LOCK_BIT 1
`define RBD_STATUS_HUNT_BIT 2
`define RBD_STATUS_WADDR_LSB 16

`define RBD_CTRL_RST 32'h00000000
`define RBD_PATTERN_RST 32'h00000000
`define RBD_TRIALS_RST 32'h00000010
`define RBD_RDADDR_RST 32'h00000000

`endif

/* src/rbd_pkg.sv */
// types shared by the ram based deserializer
package rbd_pkg;

  typedef enum logic [1:0] {
    MODE_FIXED = 2'h0,
    MODE_VAR = 2'h1,
    MODE_DDR = 2'h2
  } rbd_mode_type;

  typedef enum logic [3:0] {
    SR_IDLE = 4'h1,
    SR_HUNT = 4'h2,
    SR_LOCK = 4'h4,
    SR_MISS = 4'h8
  } rbd_search_type;

endpackage : rbd_pkg

/* src/rbd_deserializer.sv */
// ram based serial to parallel converter with storage, matching and ddr input
//
// Added by the designer: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "rbd_map.svh"
module rbd_deserializer
  import rbd_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 4,
  parameter int TRIAL_W = 16
)(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // serial line
  input wire logic serialIn,
  // parallel side
  output logic [DATA_W-1:0] parWord,
  output logic [2*DATA_W-1:0] ddrWord,
  output logic wordValid,
  output logic patternHit,
  output logic missed
);

  localparam int BIT_W = $clog2(DATA_W);
  localparam int DEPTH = 1 << ADDR_W;
  localparam logic [BIT_W-1:0] BIT_LAST = BIT_W'(DATA_W - 1);
  // all ones needs no address routing
  localparam logic [ADDR_W-1:0] FIX_ADDR_A = ADDR_W'(DEPTH - 1);
  localparam logic [ADDR_W-1:0] FIX_ADDR_B = ADDR_W'(DEPTH - 2);
  // storage keeps clear of both fixed locations
  localparam logic [ADDR_W-1:0] LAST_ADDR = ADDR_W'(DEPTH - 3);
  localparam logic [ADDR_W-1:0] FIRST_ADDR = ADDR_W'(0);

  // storage array, port a writes it, back-end reads it
  logic [DATA_W-1:0] mem [DEPTH];

  // software registers
  logic [1:0] ctrlMode_ff;
  logic matchEn_ff;
  logic policy_ff;
  logic addrDown_ff;
  logic [DATA_W-1:0] pattern_ff;
  logic [TRIAL_W-1:0] trials_ff;
  logic [ADDR_W-1:0] rdAddr_ff;
  logic [31:0] readData_ff;
  logic rdAck_ff;

  // converter state
  logic [DATA_W-1:0] doutA_ff;
  logic [DATA_W-1:0] shiftB_ff;
  logic [BIT_W-1:0] bitCnt_ff;
  logic [ADDR_W-1:0] wrAddr_ff;
  logic [DATA_W-1:0] parWord_ff;
  logic [2*DATA_W-1:0] ddrWord_ff;
  logic wordValid_ff;
  logic patternHit_ff;
  rbd_search_type search_ff;
  logic [TRIAL_W-1:0] trialCnt_ff;

  // combinational terms
  rbd_mode_type mode;
  logic [ADDR_W-1:0] addrA;
  logic [DATA_W-1:0] wdataA;
  logic [2*DATA_W-1:0] nxt_ddrWord;
  logic [ADDR_W-1:0] nxt_wrAddr;
  logic [TRIAL_W-1:0] nxt_trialCnt;
  logic termCount;
  logic wordMatch;
  logic storeWord;
  logic wrCtrl;
  logic wrPattern;
  logic wrTrials;
  logic wrRdAddr;
  logic startSearch;
  logic missEvent;
  logic [31:0] ctrlWord;
  logic [31:0] statusWord;
  logic [31:0] rdMux;

  function automatic logic [31:0] beMerge(
    input logic [31:0] oldVal,
    input logic [31:0] newVal,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = oldVal;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        res[8*i +: 8] = newVal[8*i +: 8];
      end
    end
    return res;
  endfunction : beMerge

  // bus decode; writes finish at once, reads take one wait cycle
  assign wrCtrl = avs_write && (avs_address == `RBD_CTRL_OFS);
  assign wrPattern = avs_write && (avs_address == `RBD_PATTERN_OFS);
  assign wrTrials = avs_write && (avs_address == `RBD_TRIALS_OFS);
  assign wrRdAddr = avs_write && (avs_address == `RBD_RDADDR_OFS);
  assign startSearch = wrCtrl && avs_byteenable[1] && avs_writedata[`RBD_CTRL_START_BIT];
  assign avs_waitrequest = avs_read && !rdAck_ff;
  assign avs_readdata = readData_ff;

  assign ctrlWord = 32'({addrDown_ff, policy_ff, matchEn_ff, ctrlMode_ff});
  assign statusWord = (32'(wrAddr_ff) << `RBD_STATUS_WADDR_LSB)
    | (32'(search_ff == SR_HUNT) << `RBD_STATUS_HUNT_BIT)
    | (32'(search_ff == SR_LOCK) << `RBD_STATUS_LOCK_BIT)
    | (32'(search_ff == SR_MISS) << `RBD_STATUS_MISSED_BIT);

  always_comb
  begin
    case (avs_address)
      `RBD_CTRL_OFS: rdMux = ctrlWord;
      `RBD_PATTERN_OFS: rdMux = 32'(pattern_ff);
      `RBD_TRIALS_OFS: rdMux = 32'(trials_ff);
      `RBD_STATUS_OFS: rdMux = statusWord;
      `RBD_WORD_OFS: rdMux = (mode == MODE_DDR) ? 32'(ddrWord_ff) : 32'(parWord_ff);
      `RBD_RDADDR_OFS: rdMux = 32'(rdAddr_ff);
      `RBD_RDDATA_OFS: rdMux = 32'(mem[rdAddr_ff]);
      default: rdMux = 32'h00000000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdAck_ff <= 1'b0;
      readData_ff <= 32'h00000000;
    end
    else
    begin
      rdAck_ff <= avs_read && !rdAck_ff;
      if (avs_read && !rdAck_ff)
      begin
        readData_ff <= rdMux;
      end
    end
  end

  // control register; start bit is a write-one pulse and reads back zero
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrlMode_ff <= 2'(`RBD_CTRL_RST);
      matchEn_ff <= 1'b0;
      policy_ff <= 1'b0;
      addrDown_ff <= 1'b0;
    end
    else if (wrCtrl && avs_byteenable[0])
    begin
      ctrlMode_ff <= avs_writedata[`RBD_CTRL_MODE_MSB:`RBD_CTRL_MODE_LSB];
      matchEn_ff <= avs_writedata[`RBD_CTRL_MATCH_EN_BIT];
      policy_ff <= avs_writedata[`RBD_CTRL_POLICY_BIT];
      addrDown_ff <= avs_writedata[`RBD_CTRL_DOWN_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pattern_ff <= DATA_W'(`RBD_PATTERN_RST);
      trials_ff <= TRIAL_W'(`RBD_TRIALS_RST);
      rdAddr_ff <= ADDR_W'(`RBD_RDADDR_RST);
    end
    else
    begin
      if (wrPattern)
      begin
        pattern_ff <= DATA_W'(beMerge(32'(pattern_ff), avs_writedata, avs_byteenable));
      end
      if (wrTrials)
      begin
        trials_ff <= TRIAL_W'(beMerge(32'(trials_ff), avs_writedata, avs_byteenable));
      end
      if (wrRdAddr)
      begin
        rdAddr_ff <= ADDR_W'(beMerge(32'(rdAddr_ff), avs_writedata, avs_byteenable));
      end
    end
  end

  // port a converter
  assign mode = (ctrlMode_ff == MODE_VAR) ? MODE_VAR :
    (ctrlMode_ff == MODE_DDR) ? MODE_DDR : MODE_FIXED;
  assign addrA = (mode == MODE_VAR) ? wrAddr_ff : FIX_ADDR_A;
  assign wdataA = {doutA_ff[DATA_W-2:0], serialIn};
  assign termCount = (bitCnt_ff == BIT_LAST);
  assign wordMatch = (wdataA == pattern_ff);

  // array has no reset so it can map onto a block ram
  always_ff @(posedge sys_clk)
  begin
    mem[addrA] <= wdataA;
  end

  // write-through output register; shifts on every bit, taken or not
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      doutA_ff <= '0;
    end
    else
    begin
      doutA_ff <= wdataA;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bitCnt_ff <= '0;
    end
    else
    begin
      bitCnt_ff <= termCount ? '0 : bitCnt_ff + BIT_W'(1);
    end
  end

  // port b converter on the falling edge, a shift register that writes no memory location
  always_ff @(negedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      shiftB_ff <= '0;
    end
    else
    begin
      shiftB_ff <= {shiftB_ff[DATA_W-2:0], serialIn};
    end
  end

  // port a carries odd bits, port b even bits
  for (genvar i = 0; i < DATA_W; i++)
  begin : gInterleave
    assign nxt_ddrWord[2*i+1] = wdataA[i];
    assign nxt_ddrWord[2*i] = shiftB_ff[i];
  end

  // storage decision; a failed match still reuses the location, except in SR_LOCK with policy 1
  always_comb
  begin
    storeWord = 1'b1;
    if (matchEn_ff)
    begin
      storeWord = (wordMatch && (search_ff != SR_IDLE))
        || (policy_ff && (search_ff == SR_LOCK));
    end
  end

  always_comb
  begin
    nxt_wrAddr = wrAddr_ff;
    if (addrDown_ff)
    begin
      nxt_wrAddr = (wrAddr_ff == FIRST_ADDR) ? LAST_ADDR : wrAddr_ff - ADDR_W'(1);
    end
    else
    begin
      nxt_wrAddr = (wrAddr_ff == LAST_ADDR) ? FIRST_ADDR : wrAddr_ff + ADDR_W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wrAddr_ff <= FIRST_ADDR;
    end
    else if (termCount && (mode == MODE_VAR) && storeWord)
    begin
      wrAddr_ff <= nxt_wrAddr;
    end
  end

  // parallel word offered with the address step
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      parWord_ff <= '0;
      ddrWord_ff <= '0;
      wordValid_ff <= 1'b0;
      patternHit_ff <= 1'b0;
    end
    else
    begin
      wordValid_ff <= termCount;
      patternHit_ff <= termCount && wordMatch;
      if (termCount)
      begin
        parWord_ff <= wdataA;
        if (mode == MODE_DDR)
        begin
          ddrWord_ff <= nxt_ddrWord;
        end
      end
    end
  end

  // pattern search; one trial per completed word
  assign nxt_trialCnt = trialCnt_ff + TRIAL_W'(1);
  assign missEvent = (search_ff == SR_HUNT) && termCount && !wordMatch
    && (nxt_trialCnt >= trials_ff);

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      search_ff <= SR_IDLE;
      trialCnt_ff <= '0;
    end
    else if (missEvent)
    begin
      // a miss in the same cycle as a restart is kept
      search_ff <= SR_MISS;
      trialCnt_ff <= nxt_trialCnt;
    end
    else if (startSearch)
    begin
      search_ff <= SR_HUNT;
      trialCnt_ff <= '0;
    end
    else
    begin
      case (search_ff)
        SR_IDLE:
        begin
          search_ff <= SR_IDLE;
        end
        SR_HUNT:
        begin
          if (termCount)
          begin
            trialCnt_ff <= nxt_trialCnt;
            if (wordMatch)
            begin
              search_ff <= SR_LOCK;
            end
          end
        end
        SR_LOCK:
        begin
          search_ff <= SR_LOCK;
        end
        SR_MISS:
        begin
          search_ff <= SR_MISS;
        end
        default:
        begin
          search_ff <= SR_IDLE;
        end
      endcase
    end
  end

  assign parWord = parWord_ff;
  assign ddrWord = ddrWord_ff;
  assign wordValid = wordValid_ff;
  assign patternHit = patternHit_ff;
  assign missed = (search_ff == SR_MISS);

endmodule : rbd_deserializer
`default_nettype wire

/* testbench/rbd_serial_src.sv */
// serial bit source, msb first, never pausing
`timescale 1ns/1ps
`default_nettype none
module rbd_serial_src (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // word to send and serial line
  input wire logic [7:0] txWord,
  input wire logic ddrOn,
  output logic serialIn
);
  logic [7:0] word_ff;
  logic [2:0] bit_ff;
  logic riseTag_ff;
  logic fallTag_ff;
  // next word taken at the last bit, so the line never idles
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
    begin
      word_ff <= 8'h00;
      bit_ff <= 3'h0;
      riseTag_ff <= 1'b0;
    end
    else
    begin
      riseTag_ff <= !riseTag_ff;
      bit_ff <= bit_ff + 3'h1;
      if (bit_ff == 3'h7)
        word_ff <= txWord;
    end
  // tags equal in the low half; ddr then sends the inverse there so a and b words differ
  always_ff @(negedge sys_clk or negedge resetn)
    if (!resetn)
      fallTag_ff <= 1'b0;
    else
      fallTag_ff <= riseTag_ff;
  assign serialIn = word_ff[3'h7 - bit_ff] ^ (ddrOn && (riseTag_ff == fallTag_ff));
endmodule : rbd_serial_src
`default_nettype wire

/* testbench/rbd_deserializer_props.sv */
// port checks of the ram based deserializer
`timescale 1ns/1ps
`default_nettype none
module rbd_deserializer_props #(
  parameter int DATA_W = 8
)(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // register bus
  input wire logic [4:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  // serial and parallel side
  input wire logic serialIn,
  input wire logic [DATA_W-1:0] parWord,
  input wire logic [2*DATA_W-1:0] ddrWord,
  input wire logic wordValid,
  input wire logic patternHit,
  input wire logic missed
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic [DATA_W-1:0] shift_ff;
  logic [DATA_W-1:0] pat_ff;
  logic ddr_ff;
  logic [DATA_W:0] fall_ff;
  logic [2*DATA_W-1:0] weave;
  logic ctrlWr;
  assign ctrlWr = avs_write && avs_address == 5'h00;
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
      shift_ff <= '0;
    else
      shift_ff <= {shift_ff[DATA_W-2:0], serialIn};
  // one extra bit: a falling edge has passed since the terminal edge when sampled
  always_ff @(negedge sys_clk or negedge resetn)
    if (!resetn)
      fall_ff <= '0;
    else
      fall_ff <= {fall_ff[DATA_W-1:0], serialIn};
  // pattern and mode mirrored from bus writes
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
    begin
      pat_ff <= '0;
      ddr_ff <= 1'b0;
    end
    else
    begin
      if (avs_write && avs_address == 5'h04 && avs_byteenable[0])
        pat_ff <= avs_writedata[DATA_W-1:0];
      if (ctrlWr && avs_byteenable[0])
        ddr_ff <= avs_writedata[1:0] == 2'h2;
    end
  always_comb
    for (int i = 0; i < DATA_W; i++)
      weave[2*i +: 2] = {shift_ff[i], fall_ff[i+1]};
  sequence s_quiet;
    !wordValid [*7];
  endsequence
  sequence s_next;
    s_quiet ##1 wordValid;
  endsequence
  property p_period;
    wordValid |=> s_next;
  endproperty
  a_period: assert property (p_period) else $error("strobe spacing");
  property p_shift;
    wordValid |-> parWord == shift_ff;
  endproperty
  a_shift: assert property (p_shift) else $error("word bits");
  property p_hold;
    $changed(parWord) |-> wordValid;
  endproperty
  a_hold: assert property (p_hold) else $error("word moved");
  property p_hitEq;
    wordValid |-> patternHit == (parWord == pat_ff);
  endproperty
  a_hitEq: assert property (p_hitEq) else $error("hit value");
  property p_hitOnly;
    patternHit |-> wordValid;
  endproperty
  a_hitOnly: assert property (p_hitOnly) else $error("stray hit");
  property p_ddr;
    wordValid && ddr_ff |-> ddrWord == weave;
  endproperty
  a_ddr: assert property (p_ddr) else $error("ddr word");
  property p_missRise;
    $rose(missed) |-> wordValid;
  endproperty
  a_missRise: assert property (p_missRise) else $error("miss timing");
  property p_missClr;
    ctrlWr && avs_byteenable[1] && avs_writedata[8] |=> !missed || wordValid;
  endproperty
  a_missClr: assert property (p_missClr) else $error("miss kept");
endmodule : rbd_deserializer_props
`default_nettype wire
bind rbd_deserializer rbd_deserializer_props #(.DATA_W(DATA_W)) u_props (
  .sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .serialIn(serialIn),
  .parWord(parWord), .ddrWord(ddrWord), .wordValid(wordValid), .patternHit(patternHit),
  .missed(missed)
);

/* testbench/rbd_deserializer_tb_top.sv */
// self-checking bench of the ram based deserializer
`timescale 1ns/1ps
`default_nettype none
`include "rbd_map.svh"
module rbd_deserializer_tb_top;
  logic sys_clk, resetn, avs_read, avs_write, avs_waitrequest, serialIn;
  logic wordValid, patternHit, missed, ddrOn;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable, a0;
  logic [7:0] parWord, txWord;
  logic [15:0] ddrWord;
  int n_fail, n_compared;
  rbd_deserializer DUT (
    .sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .serialIn(serialIn),
    .parWord(parWord), .ddrWord(ddrWord), .wordValid(wordValid), .patternHit(patternHit),
    .missed(missed)
  );
  rbd_serial_src u_src (
    .sys_clk(sys_clk), .resetn(resetn), .txWord(txWord), .ddrOn(ddrOn), .serialIn(serialIn)
  );
  always #5 sys_clk = ~sys_clk;
  task automatic tally_and_finish();
    if (n_fail == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  task automatic timeout();
    n_fail++;
    tally_and_finish();
  endtask : timeout
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  // returns at the edge where waitrequest is seen low
  task automatic wait_ready();
    int n;
    n = 0;
    #1;
    while (avs_waitrequest !== 1'b0)
    begin
      @(posedge sys_clk);
      #1;
      n++;
      if (n > 20)
        timeout();
    end
    @(posedge sys_clk);
  endtask : wait_ready
  task automatic bus_write(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= 1'b1;
    wait_ready();
    avs_write <= 1'b0;
  endtask : bus_write
  task automatic bus_read(input logic [4:0] a);
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    wait_ready();
    rd = avs_readdata;
    avs_read <= 1'b0;
  endtask : bus_read
  // bus work after a strobe must end within one word time
  task automatic wait_words(input int k);
    int n;
    repeat (k)
    begin
      n = 0;
      do
      begin
        @(posedge sys_clk);
        #1;
        n++;
        if (n > 20)
          timeout();
      end
      while (wordValid !== 1'b1);
    end
  endtask : wait_words
  task automatic sc_regs();
    bus_read(`RBD_CTRL_OFS);
    check(rd, `RBD_CTRL_RST);
    bus_read(`RBD_TRIALS_OFS);
    check(rd, `RBD_TRIALS_RST);
    bus_write(`RBD_STATUS_OFS, 32'hFFFFFFFF, 4'hF);
    bus_read(`RBD_STATUS_OFS);
    check(rd, 32'h00000000);
    bus_read(5'h1C);
    check(rd, 32'h00000000);
  endtask : sc_regs
  task automatic sc_fixed();
    txWord <= 8'hA5;
    wait_words(2);
    check(parWord, 8'hA5);
    bus_read(`RBD_WORD_OFS);
    check(rd, 32'h000000A5);
  endtask : sc_fixed
  task automatic sc_search();
    bus_write(`RBD_PATTERN_OFS, 32'h0000003C, 4'hF);
    bus_write(`RBD_TRIALS_OFS, 32'h00000002, 4'hF);
    bus_write(`RBD_CTRL_OFS, 32'h00000104, 4'h3);
    wait_words(4);
    check(missed, 1'b1);
    bus_read(`RBD_STATUS_OFS);
    check(rd & 32'h00000007, 32'h00000001);
    txWord <= 8'h3C;
    bus_write(`RBD_CTRL_OFS, 32'h00000104, 4'h3);
    #1;
    check(missed, 1'b0);
    wait_words(3);
    check(patternHit, 1'b1);
    bus_read(`RBD_STATUS_OFS);
    check(rd & 32'h00000007, 32'h00000002);
  endtask : sc_search
  task automatic sc_store();
    bus_write(`RBD_CTRL_OFS, 32'h00000001, 4'h1);
    wait_words(1);
    bus_read(`RBD_STATUS_OFS);
    a0 = rd[19:16];
    wait_words(1);
    bus_read(`RBD_STATUS_OFS);
    check(rd[19:16], (a0 + 4'h1) % 4'hE);
    wait_words(1);
    // a0 is two words behind the write address here
    bus_write(`RBD_RDADDR_OFS, {28'h0000000, a0}, 4'hF);
    bus_read(`RBD_RDDATA_OFS);
    check(rd, 32'h0000003C);
    wait_words(12);
    bus_read(`RBD_STATUS_OFS);
    check(rd[19:16], a0);
    bus_write(`RBD_CTRL_OFS, 32'h00000011, 4'h1);
    wait_words(1);
    bus_read(`RBD_STATUS_OFS);
    check(rd[19:16], (a0 + 4'hD) % 4'hE);
    wait_words(1);
    bus_read(`RBD_STATUS_OFS);
    check(rd[19:16], 4'hD);
  endtask : sc_store
  // policy 0 keeps only matches, policy 1 keeps all after the first match
  task automatic sc_match();
    txWord <= 8'hA5;
    bus_write(`RBD_CTRL_OFS, 32'h00000005, 4'h1);
    wait_words(2);
    bus_read(`RBD_STATUS_OFS);
    a0 = rd[19:16];
    wait_words(2);
    bus_read(`RBD_STATUS_OFS);
    check(rd[19:16], a0);
    txWord <= 8'h3C;
    wait_words(3);
    bus_read(`RBD_STATUS_OFS);
    check(rd[19:16], (a0 + 4'h2) % 4'hE);
    a0 = rd[19:16];
    txWord <= 8'hA5;
    bus_write(`RBD_CTRL_OFS, 32'h0000010D, 4'h3);
    wait_words(2);
    bus_read(`RBD_STATUS_OFS);
    check(rd[19:16], (a0 + 4'h2) % 4'hE);
    check(rd & 32'h00000007, 32'h00000002);
  endtask : sc_match
  task automatic sc_ddr();
    logic [15:0] exp;
    ddrOn <= 1'b1;
    bus_write(`RBD_CTRL_OFS, 32'h00000002, 4'h1);
    wait_words(2);
    for (int i = 0; i < 8; i++)
      exp[2*i +: 2] = {~txWord[i], txWord[i]};
    check(ddrWord, exp);
    check(parWord, txWord ^ 8'hFF);
    bus_read(`RBD_WORD_OFS);
    check(rd, {16'h0000, exp});
  endtask : sc_ddr
  initial
  begin
    sys_clk = 1'b0;
    resetn = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
    txWord = 8'h00;
    ddrOn = 1'b0;
    n_fail = 0;
    n_compared = 0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    sc_regs();
    sc_fixed();
    sc_search();
    sc_store();
    sc_match();
    sc_ddr();
    tally_and_finish();
  end
endmodule : rbd_deserializer_tb_top
`default_nettype wire
